// ### pkg/snm_pkg.sv
package snm_pkg;
	// serial command bytes
	localparam logic [7:0] SNM_WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] SNM_WRITE_DISABLE_CMD = 8'h04;
	localparam logic [7:0] SNM_STATUS_READ_CMD = 8'h05;
	localparam logic [7:0] SNM_STATUS_WRITE_CMD = 8'h01;
	localparam logic [7:0] SNM_READ_CMD = 8'h03;
	localparam logic [7:0] SNM_WRITE_CMD = 8'h02;
	// array geometry
	localparam int SNM_ADDR_W = 15;
	localparam int SNM_DEPTH = 32768;
	localparam int SNM_BYTE_W = 8;
	// status byte layout: protect-enable, two block bits, latch flag
	localparam int SNM_ST_WPEN = 7;
	localparam int SNM_ST_BP1 = 3;
	localparam int SNM_ST_BP0 = 2;
	localparam int SNM_ST_WLATCH = 1;
	localparam logic [7:0] SNM_ST_WMASK = 8'h8C;
	localparam logic [7:0] SNM_ST_RESET = 8'h00;
	// link timing: host serial clock half period in system clocks
	localparam int SNM_CLK_MHZ = 20;
	localparam int SNM_LINK_NS = 400;
	localparam int SNM_SYS_NS = 1000 / SNM_CLK_MHZ;
	localparam int SNM_HALF_CYC = (SNM_LINK_NS / SNM_SYS_NS) / 2;
	localparam logic [3:0] SNM_HALF_CNT = 4'(SNM_HALF_CYC - 1);
	// host request kinds
	typedef enum logic [2:0] {
		SNM_OP_WEN, SNM_OP_WDIS, SNM_OP_SRD, SNM_OP_SWR, SNM_OP_READ, SNM_OP_WRITE
	} snm_op_t;
endpackage

// ### pkg/snm_if.sv
`timescale 1ns/10ps
interface snm_if;
	logic sel_n;
	logic sclk;
	logic mosi;
	logic suspend_n;
	logic wprot_n;
	logic miso_o;
	logic miso_oe_n;
	// resolved serial output level, high when nobody drives
	logic miso;
	assign miso = miso_oe_n ? 1'b1 : miso_o;
	modport dev (input sel_n, input sclk, input mosi, input suspend_n, input wprot_n,
		output miso_o, output miso_oe_n);
	modport host (output sel_n, output sclk, output mosi, output suspend_n,
		output wprot_n, input miso);
endinterface

// ### rtl/snm_device.sv
`timescale 1ns/10ps
module snm_device
	import snm_pkg::*;
(
	// system
	input wire logic clock,
	input wire logic rst,
	// link
	snm_if.dev link
);
	typedef enum logic [2:0] {SNM_D_CMD, SNM_D_AH, SNM_D_AL, SNM_D_RD, SNM_D_WR,
		SNM_D_SRD, SNM_D_SWR, SNM_D_DONE} snm_dst_t;

	logic [SNM_BYTE_W-1:0] mem [SNM_DEPTH];
	logic [1:0] sclk_s_q, sel_s_q, hold_s_q, mosi_s_q, wp_s_q;
	logic sclk_prev_q, sel_prev_q;
	snm_dst_t st_q, st_d;
	logic [2:0] bit_q, bit_d;
	logic [6:0] sh_q, sh_d;
	logic [SNM_ADDR_W-1:0] addr_q, addr_d;
	logic [7:0] stat_q, stat_d;
	logic wel_q, wel_d;
	logic [7:0] tx_q, tx_d;
	logic miso_q, miso_d, oe_n_q, oe_n_d;
	logic we;
	logic [7:0] wbyte;
	logic sclk_s, sel_s, hold_s, mosi_s, wp_s;
	logic rise, fall, sel_fall;

	// two-stage synchronisers; nothing reads the first stage
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sclk_s_q <= 2'h0;
			sel_s_q <= 2'h3;
			hold_s_q <= 2'h3;
			mosi_s_q <= 2'h0;
			wp_s_q <= 2'h3;
		end else begin
			sclk_s_q <= {sclk_s_q[0], link.sclk};
			sel_s_q <= {sel_s_q[0], link.sel_n};
			hold_s_q <= {hold_s_q[0], link.suspend_n};
			mosi_s_q <= {mosi_s_q[0], link.mosi};
			wp_s_q <= {wp_s_q[0], link.wprot_n};
		end
	end
	assign sclk_s = sclk_s_q[1];
	assign sel_s = sel_s_q[1];
	assign hold_s = hold_s_q[1];
	assign mosi_s = mosi_s_q[1];
	assign wp_s = wp_s_q[1];

	// edges; prev registers only advance when not suspended, so a held edge
	// is neither lost nor replayed wrongly (host keeps clock low meanwhile)
	assign rise = hold_s && sclk_s && !sclk_prev_q;
	assign fall = hold_s && !sclk_s && sclk_prev_q;
	assign sel_fall = hold_s && !sel_s && sel_prev_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sclk_prev_q <= 1'b0;
			sel_prev_q <= 1'b1;
		end else if (hold_s) begin
			sclk_prev_q <= sclk_s;
			sel_prev_q <= sel_s;
		end
	end

	// protocol engine; clock edges plus select and suspend levels drive it, so clock pauses keep all state
	always_comb begin
		st_d = st_q;
		bit_d = bit_q;
		sh_d = sh_q;
		addr_d = addr_q;
		stat_d = stat_q;
		wel_d = wel_q;
		tx_d = tx_q;
		miso_d = miso_q;
		oe_n_d = oe_n_q;
		we = 1'b0;
		wbyte = {sh_q, mosi_s};
		if (sel_s && hold_s) begin
			st_d = SNM_D_CMD;
			bit_d = 3'h0;
			oe_n_d = 1'b1;
		end else if (sel_fall) begin
			st_d = SNM_D_CMD;
			bit_d = 3'h0;
		end else if (!hold_s) begin
			oe_n_d = 1'b1;
		end else if (rise) begin
			sh_d = wbyte[6:0];
			bit_d = bit_q + 3'h1;
			if (bit_q == 3'h7) begin
				case (st_q)
					SNM_D_CMD: begin
						case (wbyte)
							SNM_WRITE_ENABLE_CMD: begin
								wel_d = 1'b1;
								st_d = SNM_D_DONE;
							end
							SNM_WRITE_DISABLE_CMD: begin
								wel_d = 1'b0;
								st_d = SNM_D_DONE;
							end
							SNM_STATUS_READ_CMD: begin
								st_d = SNM_D_SRD;
								tx_d = {stat_q[7:2], wel_q, 1'b0};
							end
							SNM_STATUS_WRITE_CMD: st_d = SNM_D_SWR;
							SNM_READ_CMD: st_d = SNM_D_AH;
							SNM_WRITE_CMD: st_d = SNM_D_AH;
							default: st_d = SNM_D_DONE;
						endcase
						sh_d = wbyte[6:0];
						// keep read/write choice in address bit 0 until the low address byte replaces it
						addr_d[0] = (wbyte == SNM_READ_CMD);
					end
					SNM_D_AH: begin
						addr_d = {wbyte[6:0], 7'h00, addr_q[0]};
						st_d = SNM_D_AL;
					end
					SNM_D_AL: begin
						st_d = addr_q[0] ? SNM_D_RD : SNM_D_WR;
						addr_d = {addr_q[14:8], wbyte};
						tx_d = mem[{addr_q[14:8], wbyte}];
					end
					SNM_D_WR: begin
						if (wel_q) begin
							we = 1'b1;
						end
						addr_d = addr_q + 15'h0001;
					end
					SNM_D_RD: begin
						addr_d = addr_q + 15'h0001;
						tx_d = mem[addr_q + 15'h0001];
					end
					SNM_D_SWR: begin
						// protect pin low blocks every status write outright
						if (wel_q && wp_s) begin
							stat_d = (wbyte & SNM_ST_WMASK);
							wel_d = 1'b0;
						end
						st_d = SNM_D_DONE;
					end
					default: st_d = SNM_D_DONE;
				endcase
			end
		end else if (fall) begin
			// launch msb first on the fall; only in read states
			if (st_q == SNM_D_RD || st_q == SNM_D_SRD) begin
				miso_d = tx_q[3'h7 - bit_q];
				oe_n_d = 1'b0;
			end else begin
				oe_n_d = 1'b1;
			end
		end
		// a memory write burst ends with select; then the latch drops
		if (sel_s && hold_s && st_q == SNM_D_WR && wel_q) begin
			wel_d = 1'b0;
		end
	end

	// the write to the array happens in the same cycle as the eighth rise
	always_ff @(posedge clock) begin
		if (we) begin
			mem[addr_q] <= wbyte;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_q <= SNM_D_CMD;
			bit_q <= 3'h0;
			sh_q <= 7'h00;
			addr_q <= 15'h0000;
			stat_q <= SNM_ST_RESET;
			wel_q <= 1'b0;
			tx_q <= 8'h00;
			miso_q <= 1'b0;
			oe_n_q <= 1'b1;
		end else begin
			st_q <= st_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			addr_q <= addr_d;
			stat_q <= stat_d;
			wel_q <= wel_d;
			tx_q <= tx_d;
			miso_q <= miso_d;
			oe_n_q <= oe_n_d;
		end
	end

	assign link.miso_o = miso_q;
	assign link.miso_oe_n = oe_n_q;
endmodule

// ### rtl/snm_host.sv
`timescale 1ns/10ps
module snm_host
	import snm_pkg::*;
(
	// system
	input wire logic clock,
	input wire logic rst,
	// request
	input wire logic req,
	input wire snm_op_t op,
	input wire logic [SNM_ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] nbytes,
	input wire logic suspend,
	input wire logic protect,
	// answer
	output logic busy,
	output logic rvalid,
	output logic [7:0] rdata,
	// link
	snm_if.host link
);
	typedef enum logic [1:0] {SNM_H_IDLE, SNM_H_SHIFT, SNM_H_END} snm_hst_t;

	snm_hst_t st_q, st_d;
	logic [3:0] div_q, div_d;
	logic [1:0] miso_s_q;
	logic sclk_q, sclk_d, sel_q, sel_d, mosi_q, mosi_d, busy_q, busy_d;
	logic hold_q, hold_d, rv_q, rv_d;
	logic [7:0] sh_q, sh_d, rd_q, rd_d, cnt_q, cnt_d, wd_q, wd_d;
	logic [2:0] bit_q, bit_d;
	logic [1:0] hdr_q, hdr_d;
	logic [15:0] adr_q, adr_d;
	logic rd_op_q, rd_op_d, tick;
	logic dat_q, dat_d;

	// input from the device end passes two flops
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			miso_s_q <= 2'h3;
		end else begin
			miso_s_q <= {miso_s_q[0], link.miso};
		end
	end

	// half-period enable; paused while suspended, clock held low
	assign tick = (div_q == 4'h0) && (st_q == SNM_H_SHIFT) && !hold_q;

	function automatic logic [7:0] snm_code(input snm_op_t o);
		case (o)
			SNM_OP_WEN: snm_code = SNM_WRITE_ENABLE_CMD;
			SNM_OP_WDIS: snm_code = SNM_WRITE_DISABLE_CMD;
			SNM_OP_SRD: snm_code = SNM_STATUS_READ_CMD;
			SNM_OP_SWR: snm_code = SNM_STATUS_WRITE_CMD;
			SNM_OP_READ: snm_code = SNM_READ_CMD;
			default: snm_code = SNM_WRITE_CMD;
		endcase
	endfunction

	always_comb begin
		st_d = st_q;
		div_d = (div_q == 4'h0) ? SNM_HALF_CNT : div_q - 4'h1;
		sclk_d = sclk_q;
		sel_d = sel_q;
		mosi_d = mosi_q;
		busy_d = busy_q;
		hold_d = hold_q;
		rv_d = 1'b0;
		sh_d = sh_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		wd_d = wd_q;
		bit_d = bit_q;
		hdr_d = hdr_q;
		adr_d = adr_q;
		rd_op_d = rd_op_q;
		dat_d = dat_q;
		// suspend changes only with clock low, never on the edge that raises it
		if (!sclk_q && !tick) begin
			hold_d = suspend;
		end
		case (st_q)
			SNM_H_IDLE: begin
				sel_d = 1'b1;
				if (req) begin
					st_d = SNM_H_SHIFT; // fresh select fall per command
					sel_d = 1'b0;
					busy_d = 1'b1;
					sh_d = snm_code(op);
					mosi_d = sh_d[7];
					dat_d = 1'b0;
					bit_d = 3'h0;
					cnt_d = (op == SNM_OP_WEN || op == SNM_OP_WDIS) ? 8'h00 :
						(op == SNM_OP_SRD || op == SNM_OP_SWR) ? 8'h01 : nbytes;
					hdr_d = (op == SNM_OP_READ || op == SNM_OP_WRITE) ? 2'h2 : 2'h0;
					adr_d = {1'b0, addr};
					wd_d = wdata;
					rd_op_d = (op == SNM_OP_READ || op == SNM_OP_SRD);
					div_d = SNM_HALF_CNT;
				end
			end
			SNM_H_SHIFT: begin
				if (tick && !sclk_q) begin
					sclk_d = 1'b1; // device samples on this rise
				end else if (tick) begin
					// sample just before our fall: the synchronisers on both ends
					// delay the answer past the rise, but it has settled by now
					sclk_d = 1'b0;
					rd_d = {rd_q[6:0], miso_s_q[1]};
					bit_d = bit_q + 3'h1;
					if (bit_q == 3'h7) begin
						rv_d = rd_op_q && dat_q;
						dat_d = 1'b0;
						if (hdr_q != 2'h0) begin
							sh_d = (hdr_q == 2'h2) ? adr_q[15:8] : adr_q[7:0];
							hdr_d = hdr_q - 2'h1;
						end else if (cnt_q != 8'h00) begin
							sh_d = rd_op_q ? 8'h00 : wd_q;
							cnt_d = cnt_q - 8'h1;
							dat_d = 1'b1;
						end else begin
							st_d = SNM_H_END;
						end
						mosi_d = sh_d[7];
					end else begin
						sh_d = {sh_q[6:0], 1'b0};
						mosi_d = sh_q[6];
					end
				end
			end
			SNM_H_END: begin
				sel_d = 1'b1;
				busy_d = 1'b0;
				st_d = SNM_H_IDLE;
			end
			default: st_d = SNM_H_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_q <= SNM_H_IDLE;
			div_q <= 4'h0;
			sclk_q <= 1'b0;
			sel_q <= 1'b1;
			mosi_q <= 1'b0;
			busy_q <= 1'b0;
			hold_q <= 1'b0;
			rv_q <= 1'b0;
			sh_q <= 8'h00;
			rd_q <= 8'h00;
			cnt_q <= 8'h00;
			wd_q <= 8'h00;
			bit_q <= 3'h0;
			hdr_q <= 2'h0;
			adr_q <= 16'h0000;
			rd_op_q <= 1'b0;
			dat_q <= 1'b0;
		end else begin
			st_q <= st_d;
			div_q <= div_d;
			sclk_q <= sclk_d;
			sel_q <= sel_d;
			mosi_q <= mosi_d;
			busy_q <= busy_d;
			hold_q <= hold_d;
			rv_q <= rv_d;
			sh_q <= sh_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			wd_q <= wd_d;
			bit_q <= bit_d;
			hdr_q <= hdr_d;
			adr_q <= adr_d;
			rd_op_q <= rd_op_d;
			dat_q <= dat_d;
		end
	end

	assign busy = busy_q;
	assign rvalid = rv_q;
	assign rdata = rd_q;
	assign link.sclk = sclk_q;
	assign link.sel_n = sel_q;
	assign link.mosi = mosi_q;
	assign link.suspend_n = !hold_q;
	assign link.wprot_n = !protect;
endmodule

// ### sim/snm_properties.sv
`timescale 1ns/10ps
module snm_properties (
	// system
	input wire logic clock,
	input wire logic rst,
	// link
	input wire logic sel_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic suspend_n,
	input wire logic wprot_n,
	input wire logic miso_o,
	input wire logic miso_oe_n
);
	logic sclk_q;
	logic [15:0] rise_q;
	logic [15:0] rise_d;
	// clock rises seen in the current frame
	always_comb begin
		rise_d = rise_q;
		if (sel_n) begin
			rise_d = 16'h0000;
		end else if (sclk && !sclk_q) begin
			rise_d = rise_q + 16'h0001;
		end
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sclk_q <= 1'b0;
			rise_q <= 16'h0000;
		end else begin
			sclk_q <= sclk;
			rise_q <= rise_d;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// four cycles of margin for the device's input synchronisers
	chk_standby_float: assert property (sel_n [*4] |-> miso_oe_n)
		else $error("output driven in standby");
	chk_suspend_float: assert property (!suspend_n [*4] |-> miso_oe_n)
		else $error("output driven while suspended");
	chk_suspend_clk_low: assert property ($changed(suspend_n) |-> !sclk)
		else $error("suspend moved with clock high");
	chk_half_period: assert property ($changed(sclk) |=> $stable(sclk) [*3])
		else $error("serial clock half period short");
	chk_mosi_settled: assert property ($rose(sclk) |-> $stable(mosi))
		else $error("data moved at clock rise");
	chk_launch_low: assert property (!miso_oe_n && $changed(miso_o) |-> !sclk)
		else $error("output launched with clock high");
	chk_cmd_quiet: assert property (!sel_n && rise_q < 16'h0008 |-> miso_oe_n)
		else $error("output driven during command");
	chk_whole_bytes: assert property ($rose(sel_n) |-> rise_q[2:0] == 3'h0)
		else $error("frame not whole bytes");
	chk_select_clk: assert property ($fell(sel_n) || $rose(sel_n) |-> !sclk)
		else $error("select moved with clock high");
	chk_select_gap: assert property ($rose(sel_n) |=> sel_n)
		else $error("select high too briefly");
	cover property ($fell(sel_n));
	cover property ($fell(miso_oe_n));
	cover property ($fell(suspend_n));
endmodule

// ### sim/test_spi_nonvolatile_byte_memory.sv
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
	$display("[ERR] %s exp %h got %h", nm, ex, gt); fails++; end end
module test_spi_nonvolatile_byte_memory import snm_pkg::*; ;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic req = 1'b0;
	snm_op_t op = SNM_OP_WEN;
	logic [SNM_ADDR_W-1:0] addr = 15'h0000;
	logic [7:0] wdata = 8'h00;
	logic [7:0] nbytes = 8'h00;
	logic suspend = 1'b0;
	logic protect = 1'b0;
	logic busy;
	logic rvalid;
	logic [7:0] rdata;
	logic [7:0] got;
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	int n_rv = 0;
	snm_if link_if();
	snm_device snm_device_inst (.clock(clock), .rst(rst), .link(link_if));
	snm_host snm_host_inst (.clock(clock), .rst(rst), .req(req), .op(op), .addr(addr),
		.wdata(wdata), .nbytes(nbytes), .suspend(suspend), .protect(protect),
		.busy(busy), .rvalid(rvalid), .rdata(rdata), .link(link_if));
	snm_properties snm_properties_inst (.clock(clock), .rst(rst), .sel_n(link_if.sel_n),
		.sclk(link_if.sclk), .mosi(link_if.mosi), .suspend_n(link_if.suspend_n),
		.wprot_n(link_if.wprot_n), .miso_o(link_if.miso_o), .miso_oe_n(link_if.miso_oe_n));
	// 50 ns system clock
	initial begin
		forever #25 clock = ~clock;
	end
	// hang guard, far above the few thousand cycles the tests need
	always @(posedge clock) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			report_and_stop();
		end
	end
	// read bytes handed over by the host end
	always @(posedge clock) begin
		if (rvalid === 1'b1) n_rv++;
	end
	task report_and_stop;
		if (fails == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// one host request; hold > 0 suspends the frame that many cycles in
	task xfer(input snm_op_t o, input logic [14:0] a, input logic [7:0] d,
		input logic [7:0] n, input int hold);
		int i;
		@(negedge clock);
		op = o;
		addr = a;
		wdata = d;
		nbytes = n;
		req = 1'b1;
		@(negedge clock);
		req = 1'b0;
		if (hold > 0) begin
			repeat (hold) @(negedge clock);
			suspend = 1'b1;
			repeat (40) @(negedge clock);
			`CHK("miso_oe_n", 1'b1, link_if.miso_oe_n)
			`CHK("busy", 1'b1, busy)
			suspend = 1'b0;
		end
		for (i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clock);
		repeat (4) @(negedge clock);
		got = rdata;
	endtask
	task t_reset;
		`CHK("oe_n", 1'b1, link_if.miso_oe_n)
		`CHK("miso", 1'b1, link_if.miso)
	endtask
	task t_latch;
		xfer(SNM_OP_WEN, 15'h0000, 8'h00, 8'h00, 0);
		xfer(SNM_OP_SRD, 15'h0000, 8'h00, 8'h00, 0);
		`CHK("status", 8'h02, got)
		xfer(SNM_OP_WDIS, 15'h0000, 8'h00, 8'h00, 0);
		xfer(SNM_OP_SRD, 15'h0000, 8'h00, 8'h00, 0);
		`CHK("status", 8'h00, got)
		xfer(SNM_OP_WEN, 15'h0000, 8'h00, 8'h00, 0);
		xfer(SNM_OP_WRITE, 15'h0010, 8'h11, 8'h01, 0);
		xfer(SNM_OP_READ, 15'h0010, 8'h00, 8'h01, 0);
		`CHK("mem", 8'h11, got)
		xfer(SNM_OP_SRD, 15'h0000, 8'h00, 8'h00, 0);
		`CHK("status", 8'h00, got)
		// latch now clear, so this write must vanish
		xfer(SNM_OP_WRITE, 15'h0010, 8'h22, 8'h01, 0);
		xfer(SNM_OP_READ, 15'h0010, 8'h00, 8'h01, 0);
		`CHK("mem", 8'h11, got)
	endtask
	task t_status;
		xfer(SNM_OP_SWR, 15'h0000, 8'hFF, 8'h00, 0);
		xfer(SNM_OP_SRD, 15'h0000, 8'h00, 8'h00, 0);
		`CHK("status", 8'h00, got)
		xfer(SNM_OP_WEN, 15'h0000, 8'h00, 8'h00, 0);
		xfer(SNM_OP_SWR, 15'h0000, 8'hFF, 8'h00, 0);
		xfer(SNM_OP_SRD, 15'h0000, 8'h00, 8'h00, 0);
		`CHK("status", SNM_ST_WMASK, got)
		protect = 1'b1;
		xfer(SNM_OP_WEN, 15'h0000, 8'h00, 8'h00, 0);
		xfer(SNM_OP_SWR, 15'h0000, 8'h00, 8'h00, 0);
		xfer(SNM_OP_SRD, 15'h0000, 8'h00, 8'h00, 0);
		`CHK("status", SNM_ST_WMASK, got & SNM_ST_WMASK)
		protect = 1'b0;
		xfer(SNM_OP_WEN, 15'h0000, 8'h00, 8'h00, 0);
		xfer(SNM_OP_SWR, 15'h0000, 8'h00, 8'h00, 0);
		xfer(SNM_OP_SRD, 15'h0000, 8'h00, 8'h00, 0);
		`CHK("status", 8'h00, got)
		// protect pin alone leaves the array writable
		protect = 1'b1;
		xfer(SNM_OP_WEN, 15'h0000, 8'h00, 8'h00, 0);
		xfer(SNM_OP_WRITE, 15'h7FFF, 8'hA5, 8'h01, 0);
		xfer(SNM_OP_READ, 15'h7FFF, 8'h00, 8'h01, 0);
		`CHK("mem top", 8'hA5, got)
		protect = 1'b0;
	endtask
	task t_burst;
		int i;
		xfer(SNM_OP_WEN, 15'h0000, 8'h00, 8'h00, 0);
		xfer(SNM_OP_WRITE, 15'h1234, 8'h3C, 8'h03, 0);
		for (i = 0; i < 3; i++) begin
			xfer(SNM_OP_READ, 15'h1234 + 15'(i), 8'h00, 8'h01, 0);
			`CHK("burst", 8'h3C, got)
		end
		// one frame streams three bytes, each handed over once
		i = n_rv;
		xfer(SNM_OP_READ, 15'h1234, 8'h00, 8'h03, 0);
		`CHK("stream", 8'h3C, got)
		`CHK("rvalid count", 3, n_rv - i)
	endtask
	task t_suspend;
		xfer(SNM_OP_WEN, 15'h0000, 8'h00, 8'h00, 0);
		xfer(SNM_OP_WRITE, 15'h0100, 8'hC3, 8'h01, 100);
		xfer(SNM_OP_READ, 15'h0100, 8'h00, 8'h01, 0);
		`CHK("held write", 8'hC3, got)
		// suspend lands in the read data byte
		xfer(SNM_OP_READ, 15'h0100, 8'h00, 8'h01, 200);
		`CHK("held read", 8'hC3, got)
	endtask
	initial begin
		repeat (16) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		repeat (4) @(negedge clock);
		t_reset();
		t_latch();
		t_status();
		t_burst();
		t_suspend();
		report_and_stop();
	end
endmodule
